// ### vt_circuit_supervisor.sv
`timescale 1ns/1ps

// Behaviour
// - Zero mode: failure when residual voltage high and residual current low.
// - Negative mode: failure when negative voltage high and negative current low.
// - Special mode: residual voltage high, residual and negative currents both low.
// - Triggering allowed only after live line held continuously for 200 ms.
// - No new triggering while the dead line flag is present.
// - With live line, failure clears 200 ms after criteria cease.
// - Dead line after at least 100 ms of failure latches the failure.
// - Dead line after under 100 ms of failure clears the failure.
// - Block input disables supervision and forces the failure output low.
// - Operation selector off, negative, zero, special; negative by default; off idles.
// - Residual voltage limit in 1 % steps, default 30 %.
// - Residual current limit in 1 % steps, default 10 %.
// - Negative sequence voltage limit in 1 % steps, default 10 %.
// - Negative sequence current limit in 1 % steps, default 10 %.
// - One binary failure output showing trigger, hold and reset behaviour.
module vt_circuit_supervisor
  import vts_pkg::*;
#(
  parameter int ARM_TICKS     = ARM_CYC,
  parameter int RELEASE_TICKS = RELEASE_CYC,
  parameter int LATCH_TICKS   = LATCH_CYC
)
(
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  input  wire logic                clk_en,
  input  wire vts_pkg::vts_meas_t  meas,
  input  wire logic                live_line_flag,
  input  wire logic                dead_line_flag,
  input  wire logic                supervision_block_in,
  input  wire logic [vts_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  output logic                     vt_failure_out,
  output logic                     irq
);
  import vts_pkg::*;

  // ****************************************************************
  // Constants and state
  // ****************************************************************

  localparam logic [TMR_W-1:0] ARM_T = TMR_W'(ARM_TICKS);
  localparam logic [TMR_W-1:0] REL_T = TMR_W'(RELEASE_TICKS);
  localparam logic [TMR_W-1:0] LAT_T = TMR_W'(LATCH_TICKS);

  vts_regs_t s_r;
  vts_regs_t s_nxt;

  logic       live_s;
  logic       dead_s;
  logic       blk_s;
  logic       crit;
  logic       op_on;
  logic       held_long;
  logic       trig_ok;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;

  // Line flags and block come from other logic groups; two stages keep them clean.
  assign live_s = s_r.live_sync[1];
  assign dead_s = s_r.dead_sync[1];
  assign blk_s  = s_r.blk_sync[1];

  // ****************************************************************
  // Criteria
  // ****************************************************************

  // Strict compares against the stored limits.
  always_comb
  begin
    crit = 1'b0;
    case (s_r.cfg.op)
      VTS_OP_ZERO:
        crit = (meas.residual_voltage > s_r.cfg.res_v_limit) &&
               (meas.residual_current < s_r.cfg.res_i_limit);
      VTS_OP_NEG:
        crit = (meas.neg_seq_voltage > s_r.cfg.neg_v_limit) &&
               (meas.neg_seq_current < s_r.cfg.neg_i_limit);
      VTS_OP_SPEC:
        crit = (meas.residual_voltage > s_r.cfg.res_v_limit) &&
               (meas.residual_current < s_r.cfg.res_i_limit) &&
               (meas.neg_seq_current < s_r.cfg.neg_i_limit);
      VTS_OP_OFF:
        crit = 1'b0;
      default:
        crit = 1'b0;
    endcase
  end

  assign op_on     = (s_r.cfg.op != VTS_OP_OFF) && !blk_s;
  assign held_long = (s_r.fail_cnt >= LAT_T);
  // Dead line wins over a stale armed flag, so reclosing cannot trigger early.
  assign trig_ok   = op_on && s_r.armed && live_s && !dead_s;

  // Write-only clear register, decoded here so the set can win below.
  assign clr = (reg_wr && reg_addr == REG_IRQ_CL) ? reg_wdata[IRQ_W-1:0] : '0;

  // ****************************************************************
  // Next state
  // ****************************************************************

  always_comb
  begin
    s_nxt = s_r;
    ev    = '0;

    if (clk_en)
    begin
      s_nxt.live_sync = {s_r.live_sync[0], live_line_flag};
      s_nxt.dead_sync = {s_r.dead_sync[0], dead_line_flag};
      s_nxt.blk_sync  = {s_r.blk_sync[0], supervision_block_in};

      // Arming timer needs an unbroken live line indication.
      if (!live_s)
      begin
        s_nxt.live_cnt = '0;
        s_nxt.armed    = 1'b0;
      end
      else if (s_r.live_cnt >= ARM_T)
        s_nxt.armed = 1'b1;
      else
        s_nxt.live_cnt = s_r.live_cnt + 1'b1;

      // Failure flag sequence.
      if (!op_on)
      begin
        s_nxt.state    = VTS_ST_IDLE;
        s_nxt.fail_cnt = '0;
        s_nxt.rel_cnt  = '0;
      end
      else
      begin
        case (s_r.state)
          VTS_ST_IDLE:
          begin
            s_nxt.fail_cnt = '0;
            s_nxt.rel_cnt  = '0;
            if (trig_ok && crit)
              s_nxt.state = VTS_ST_FAIL;
          end
          VTS_ST_FAIL, VTS_ST_RELEASE:
          begin
            if (s_r.fail_cnt < LAT_T)
              s_nxt.fail_cnt = s_r.fail_cnt + 1'b1;
            if (dead_s)
              s_nxt.state = held_long ? VTS_ST_LATCHED
                                      : VTS_ST_IDLE;
            else if (crit)
            begin
              s_nxt.state   = VTS_ST_FAIL;
              s_nxt.rel_cnt = '0;
            end
            else if (s_r.rel_cnt + 1'b1 >= REL_T)
              s_nxt.state = VTS_ST_IDLE;
            else
            begin
              s_nxt.state   = VTS_ST_RELEASE;
              s_nxt.rel_cnt = s_r.rel_cnt + 1'b1;
            end
          end
          VTS_ST_LATCHED:
          begin
            // Held through the dead period; once live again it releases normally.
            if (!dead_s && live_s)
            begin
              s_nxt.state   = VTS_ST_RELEASE;
              s_nxt.rel_cnt = '0;
            end
          end
          default:
            s_nxt.state = VTS_ST_IDLE;
        endcase
      end
    end

    s_nxt.failure = (s_nxt.state != VTS_ST_IDLE);

    // Events: rising and falling edges of the failure flag.
    ev[IRQ_RISE] = s_nxt.failure && !s_r.failure;
    ev[IRQ_FALL] = !s_nxt.failure && s_r.failure;
    // Set wins over a simultaneous clear.
    s_nxt.irq_st = (s_r.irq_st & ~clr) | ev;

    // Register writes.
    if (reg_wr)
    begin
      case (reg_addr)
        REG_CTRL:
          s_nxt.cfg.op = vts_op_t'(reg_wdata[1:0]);
        REG_LIMITS:
        begin
          s_nxt.cfg.res_v_limit = reg_wdata[7:0];
          s_nxt.cfg.res_i_limit = reg_wdata[15:8];
          s_nxt.cfg.neg_v_limit = reg_wdata[23:16];
          s_nxt.cfg.neg_i_limit = reg_wdata[31:24];
        end
        REG_IRQ_EN:
          s_nxt.irq_en = reg_wdata[IRQ_W-1:0];
        default:
          s_nxt.irq_en = s_r.irq_en;
      endcase
    end

    // Read data, valid the cycle after the strobe; unmapped reads give zero.
    s_nxt.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL:
          s_nxt.rdata = {30'h0, s_r.cfg.op};
        REG_LIMITS:
          s_nxt.rdata = {s_r.cfg.neg_i_limit, s_r.cfg.neg_v_limit,
                         s_r.cfg.res_i_limit, s_r.cfg.res_v_limit};
        REG_STATE:
          s_nxt.rdata = {26'h0, s_r.state, dead_s, live_s, s_r.armed, s_r.failure};
        REG_IRQ_ST:
          s_nxt.rdata = {30'h0, s_r.irq_st};
        REG_IRQ_EN:
          s_nxt.rdata = {30'h0, s_r.irq_en};
        default:
          s_nxt.rdata = '0;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Asynchronous reset loads the documented defaults.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_r                 <= '0;
      s_r.cfg.op          <= OP_RESET;
      s_r.cfg.res_v_limit <= RES_V_LIM_RESET;
      s_r.cfg.res_i_limit <= RES_I_LIM_RESET;
      s_r.cfg.neg_v_limit <= NEG_V_LIM_RESET;
      s_r.cfg.neg_i_limit <= NEG_I_LIM_RESET;
      s_r.state           <= VTS_ST_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  // Failure and read data straight from flip-flops; irq is the OR of the enabled status bits.
  assign vt_failure_out = s_r.failure;
  assign reg_rdata      = s_r.rdata;
  assign irq            = |(s_r.irq_st & s_r.irq_en);

endmodule

// ### vt_circuit_supervisor_tb.sv
`timescale 1ns/1ps
// ****
// Supervisor testbench
// ****
module vt_circuit_supervisor_tb;
  import vts_pkg::*;
  localparam int ARM = 20;
  localparam int REL = 20;
  localparam int LAT = 10;
  localparam vts_meas_t TRIG = 32'h00001400;
  logic            sys_clk = 1'b0;
  logic            reset_n = 1'b0;
  logic            clk_en = 1'b0;
  logic            blk = 1'b0;
  logic [2:0][7:0] pv = '0;
  logic [2:0][7:0] pi = '0;
  vts_meas_t       mi = '0;
  vts_meas_t       meas;
  vts_meas_t       m;
  logic            live;
  logic            dead;
  logic [7:0]      addr = '0;
  logic [31:0]     wdata = '0;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic            rd_d = 1'b0;
  logic [31:0]     rdata;
  logic [31:0]     lim;
  logic            fail;
  logic            irq;
  logic [31:0]     exp_q [$];
  vts_op_t         ops [4] = '{VTS_OP_NEG, VTS_OP_ZERO, VTS_OP_SPEC, VTS_OP_OFF};
  int              failures = 0;
  int              compares = 0;
  int              seed = 73;
  int              cyc = 0;

  vts_front_end i_vts_front_end (
    .phase_v(pv),
    .phase_i(pi),
    .meas_in(mi),
    .meas(meas),
    .live_line_flag(live),
    .dead_line_flag(dead)
  );

  vt_circuit_supervisor #(
    .ARM_TICKS(ARM),
    .RELEASE_TICKS(REL),
    .LATCH_TICKS(LAT)
  ) i_vt_circuit_supervisor (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .meas(meas),
    .live_line_flag(live),
    .dead_line_flag(dead),
    .supervision_block_in(blk),
    .reg_addr(addr),
    .reg_wdata(wdata),
    .reg_wr(wr),
    .reg_rd(rd),
    .reg_rdata(rdata),
    .vt_failure_out(fail),
    .irq(irq)
  );

  // Free running clock.
  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(logic [31:0] seen, logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      failures++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask

  // A hung wait is cut short and counted as a mismatch.
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      finish_test();
    end
  end

  // Read data stand only in the cycle after the strobe, so they are taken at that negedge.
  always @(posedge sys_clk) rd_d <= rd;
  always @(negedge sys_clk)
  begin
    if (rd_d)
      check(rdata, exp_q.pop_front());
  end

  function automatic logic [7:0] rnd(int span);
    return 8'($unsigned($random(seed)) % span);
  endfunction

  function automatic logic crit(vts_op_t o, vts_meas_t v, logic [31:0] l);
    case (o)
      VTS_OP_NEG: return v.neg_seq_voltage > l[23:16] && v.neg_seq_current < l[31:24];
      VTS_OP_ZERO: return v.residual_voltage > l[7:0] && v.residual_current < l[15:8];
      VTS_OP_SPEC: return v.residual_voltage > l[7:0] && v.residual_current < l[15:8]
                          && v.neg_seq_current < l[31:24];
      default: return 1'b0;
    endcase
  endfunction

  task automatic reg_write(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic reg_read(logic [7:0] a, logic [31:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic set_m(vts_meas_t v);
    @(posedge sys_clk);
    mi <= v;
  endtask

  task automatic line(logic up);
    @(posedge sys_clk);
    pv <= up ? {3{8'h64}} : '0;
    pi <= up ? {3{8'h32}} : '0;
  endtask

  // Waits a bounded number of cycles for the failure output, then compares it.
  task automatic wait_fail(logic e, int n);
    @(negedge sys_clk);
    repeat (n) if (fail !== e) @(negedge sys_clk);
    check({31'h0, fail}, {31'h0, e});
  endtask

  // Main sequence; clock enable stays low through reset and four more cycles, and nothing is checked until it rises.
  initial
  begin
    tick(3);
    reset_n <= 1'b1;
    tick(4);
    clk_en <= 1'b1;
    reg_read(REG_CTRL, 32'h1);
    reg_read(REG_LIMITS, 32'h0a0a0a1e);
    reg_read(REG_IRQ_ST, 32'h0);
    reg_read(8'h20, 32'h0);
    reg_write(REG_IRQ_EN, 32'h3);
    line(1'b1);
    set_m(TRIG);
    tick(ARM / 2);
    wait_fail(1'b0, 0);
    wait_fail(1'b1, 3 * ARM);
    check({31'h0, irq}, 32'h1);
    set_m('0);
    tick(REL / 2);
    wait_fail(1'b1, 0);
    wait_fail(1'b0, REL + 5);
    reg_read(REG_IRQ_ST, 32'h3);
    reg_write(REG_IRQ_EN, 32'h0);
    @(negedge sys_clk);
    check({31'h0, irq}, 32'h0);
    reg_write(REG_IRQ_CL, 32'h3);
    reg_read(REG_IRQ_ST, 32'h0);
    reg_write(REG_IRQ_EN, 32'h3);
    set_m(32'h00000a00);
    tick(5);
    wait_fail(1'b0, 0);
    $display("defaults test done");
    foreach (ops[j])
    begin
      for (int b = 0; b < 4; b++) lim[8*b+:8] = 8'h05 + rnd(36);
      reg_write(REG_CTRL, {30'h0, ops[j]});
      reg_write(REG_LIMITS, lim);
      reg_read(REG_LIMITS, lim);
      reg_read(REG_CTRL, {30'h0, ops[j]});
      repeat (6)
      begin
        for (int b = 0; b < 4; b++) m[8*b+:8] = rnd(46);
        set_m(m);
        tick(3);
        wait_fail(crit(ops[j], m, lim), 0);
        set_m('0);
        wait_fail(1'b0, REL + 5);
      end
    end
    $display("modes test done");
    reg_write(REG_CTRL, 32'h1);
    reg_write(REG_LIMITS, 32'h0a0a0a1e);
    set_m(TRIG);
    wait_fail(1'b1, 3 * ARM);
    tick(LAT + 5);
    line(1'b0);
    set_m('0);
    tick(2 * REL);
    wait_fail(1'b1, 0);
    reg_read(REG_STATE, 32'h39);
    line(1'b1);
    wait_fail(1'b1, 2);
    wait_fail(1'b0, 3 * REL);
    $display("latch test done");
    set_m(TRIG);
    wait_fail(1'b1, 3 * ARM);
    line(1'b0);
    wait_fail(1'b0, 6);
    tick(2 * ARM);
    wait_fail(1'b0, 0);
    line(1'b1);
    tick(ARM / 2);
    wait_fail(1'b0, 0);
    wait_fail(1'b1, 3 * ARM);
    $display("dead line test done");
    @(posedge sys_clk);
    blk <= 1'b1;
    wait_fail(1'b0, 8);
    tick(2 * ARM);
    wait_fail(1'b0, 0);
    @(posedge sys_clk);
    blk <= 1'b0;
    wait_fail(1'b1, 3 * ARM);
    $display("block test done");
    // With the enable low the failure must not release although criteria are gone.
    @(posedge sys_clk);
    clk_en <= 1'b0;
    set_m('0);
    tick(2 * REL);
    wait_fail(1'b1, 0);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    wait_fail(1'b0, REL + 5);
    $display("freeze test done");
    finish_test();
  end
endmodule

// ### vts_front_end.sv
`timescale 1ns/1ps
// ****
// Measurement front end and line state detector
// ****
module vts_front_end
#(
  parameter int V_PCT = 60,
  parameter int I_PCT = 10
)
(
  input  wire logic [2:0][7:0]   phase_v,
  input  wire logic [2:0][7:0]   phase_i,
  input  wire vts_pkg::vts_meas_t meas_in,
  output vts_pkg::vts_meas_t     meas,
  output logic                   live_line_flag,
  output logic                   dead_line_flag
);
  // The detector is never switched off, so its flags are always meaningful.
  always_comb
  begin
    live_line_flag = 1'b1;
    dead_line_flag = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      live_line_flag &= phase_v[k] > V_PCT;
      dead_line_flag &= phase_v[k] < V_PCT && phase_i[k] < I_PCT;
    end
  end

  // Magnitudes arrive already in percent of rated value.
  assign meas = meas_in;
endmodule

// ### vts_pkg.sv
package vts_pkg;

  // ****************************************************************
  // Operation selector and setting layout
  // ****************************************************************

  // Operation selector codes.
  typedef enum logic [1:0]
  {
    VTS_OP_OFF  = 2'b00,
    VTS_OP_NEG  = 2'b01,
    VTS_OP_ZERO = 2'b10,
    VTS_OP_SPEC = 2'b11
  } vts_op_t;

  localparam int PCT_W = 8;

  // Setting limits in percent of rated value, one percent per step.
  typedef struct packed
  {
    vts_op_t            op;
    logic [PCT_W-1:0]   res_v_limit;
    logic [PCT_W-1:0]   res_i_limit;
    logic [PCT_W-1:0]   neg_v_limit;
    logic [PCT_W-1:0]   neg_i_limit;
  } vts_cfg_t;

  // Measured magnitudes in percent of rated value.
  typedef struct packed
  {
    logic [PCT_W-1:0]   residual_voltage;
    logic [PCT_W-1:0]   residual_current;
    logic [PCT_W-1:0]   neg_seq_voltage;
    logic [PCT_W-1:0]   neg_seq_current;
  } vts_meas_t;

  // Default settings.
  localparam vts_op_t          OP_RESET          = VTS_OP_NEG;
  localparam logic [PCT_W-1:0] RES_V_LIM_RESET   = 8'h1e;
  localparam logic [PCT_W-1:0] RES_I_LIM_RESET   = 8'h0a;
  localparam logic [PCT_W-1:0] NEG_V_LIM_RESET   = 8'h0a;
  localparam logic [PCT_W-1:0] NEG_I_LIM_RESET   = 8'h0a;

  // ****************************************************************
  // Timing
  // ****************************************************************

  localparam int CLK_HZ       = 50_000_000;
  localparam int ARM_MS       = 200;
  localparam int RELEASE_MS   = 200;
  localparam int LATCH_MS     = 100;
  localparam int ARM_CYC      = ARM_MS * (CLK_HZ / 1000);
  localparam int RELEASE_CYC  = RELEASE_MS * (CLK_HZ / 1000);
  localparam int LATCH_CYC    = LATCH_MS * (CLK_HZ / 1000);
  localparam int TMR_W        = 24;

  // Interrupt bit positions.
  localparam int IRQ_W        = 2;
  localparam int IRQ_RISE     = 0;
  localparam int IRQ_FALL     = 1;

  // Register map, byte addresses.
  localparam int ADDR_W       = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_LIMITS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATE  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_ST = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_CL = 8'h14;

  // State of the supervision flag.
  typedef enum logic [1:0]
  {
    VTS_ST_IDLE    = 2'b00,
    VTS_ST_FAIL    = 2'b01,
    VTS_ST_RELEASE = 2'b10,
    VTS_ST_LATCHED = 2'b11
  } vts_state_t;

  // Whole state of the supervisor.
  typedef struct packed
  {
    vts_cfg_t           cfg;
    logic [IRQ_W-1:0]   irq_en;
    logic [IRQ_W-1:0]   irq_st;
    logic [31:0]        rdata;
    logic [1:0]         live_sync;
    logic [1:0]         dead_sync;
    logic [1:0]         blk_sync;
    logic [TMR_W-1:0]   live_cnt;
    logic               armed;
    vts_state_t         state;
    logic [TMR_W-1:0]   fail_cnt;
    logic [TMR_W-1:0]   rel_cnt;
    logic               failure;
  } vts_regs_t;

endpackage

// ### vts_properties.sv
`timescale 1ns/1ps
// ****
// Supervisor checker
// ****
module vts_properties
#(
  parameter int ARM_TICKS     = 20,
  parameter int RELEASE_TICKS = 20,
  parameter int LATCH_TICKS   = 10
)
(
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic        live_line_flag,
  input wire logic        dead_line_flag,
  input wire logic        supervision_block_in,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        vt_failure_out
);
  logic [15:0] live_r;
  logic [15:0] hi_r;

  // Runs of live ticks and of failure cycles; saturating so long runs never wrap.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      live_r <= '0;
      hi_r   <= '0;
    end
    else
    begin
      live_r <= !live_line_flag ? '0 : live_r + 16'(clk_en && live_r != 16'hffff);
      hi_r   <= !vt_failure_out ? '0 : hi_r + 16'(hi_r != 16'hffff);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // The margins below cover the two-tick flag synchroniser.
  property p_block;
    (supervision_block_in && clk_en)[*5] |=> !vt_failure_out;
  endproperty
  a_block: assert property (p_block) else $error("failure high while blocked");
  property p_dead;
    dead_line_flag[*4] |=> !$rose(vt_failure_out);
  endproperty
  a_dead: assert property (p_dead) else $error("failure rose on dead line");
  property p_arm;
    $rose(vt_failure_out) |-> live_r >= ARM_TICKS;
  endproperty
  a_arm: assert property (p_arm) else $error("failure rose before arming");
  property p_rel;
    $fell(vt_failure_out) && live_line_flag && !dead_line_flag && !supervision_block_in
      |-> hi_r >= RELEASE_TICKS - 1;
  endproperty
  a_rel: assert property (p_rel) else $error("failure released too early");
  property p_latch;
    vt_failure_out && dead_line_flag && !supervision_block_in && hi_r >= LATCH_TICKS + 4
      |=> vt_failure_out;
  endproperty
  a_latch: assert property (p_latch) else $error("held failure dropped");
  property p_short;
    $rose(dead_line_flag) && vt_failure_out && hi_r < LATCH_TICKS - 3 |-> ##[1:6] !vt_failure_out;
  endproperty
  a_short: assert property (p_short) else $error("short failure not cleared");
  property p_rdata;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
  property p_freeze;
    !clk_en ##1 !clk_en |=> $stable(vt_failure_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("failure moved without tick");

  c_rise: cover property ($rose(vt_failure_out));
  c_latch: cover property (dead_line_flag && vt_failure_out);
  c_block: cover property (supervision_block_in && $fell(vt_failure_out));
endmodule

bind vt_circuit_supervisor vts_properties #(
  .ARM_TICKS(ARM_TICKS),
  .RELEASE_TICKS(RELEASE_TICKS),
  .LATCH_TICKS(LATCH_TICKS)
) i_vts_properties (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .clk_en(clk_en),
  .live_line_flag(live_line_flag),
  .dead_line_flag(dead_line_flag),
  .supervision_block_in(supervision_block_in),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .vt_failure_out(vt_failure_out)
);
